// *** inc/sram_port_pkg.sv ***
/*
  Constants, carriers and state names shared by the synchronous SRAM port, its host controller model and its bench.
  Assumes the port sits behind the SRAM pins and is driven by a memory controller on clk_sys.

  // Functional notes
  // - Sample test mode-select on each test-clock rise
  // - Sampled address selects one of 512K locations
  // - Low two address bits feed burst counter
  // - Active-low lane selects write only with strobe
  // - Write strobe sampled only on qualified edges
  // - Advance-load high on qualified edge steps counter
  // - Advance-load low on qualified edge loads address
  // - Edges ignored while clock-qualify is high
  // - All synchronous inputs captured on clock rise
  // - Second chip select is active high
  // - Selected only when all three selects asserted
  // - Strap low linear, high or open interleaved
  // - Clock-qualify high stretches cycle, keeps state
  // - Read data from address of previous edge
  // - Outputs float on write, after deselect, deselected
*/
`default_nettype none
package sram_port_pkg;
  localparam int ADDR_W = 19;
  localparam int MEM_WORDS = 524288;
  localparam int DATA_W = 18;
  localparam int LANES = 2;
  localparam int LANE_W = 9;
  localparam int BURST_W = 2;
  localparam int FIFO_DEPTH = 8;
  localparam logic STRAP_LINEAR = 1'b0;
  localparam logic [BURST_W-1:0] SEQ_START = 2'h0;
  localparam logic [BURST_W-1:0] SEQ_STEP = 2'h1;
  localparam logic [DATA_W-1:0] DATA_RESET = 18'h00000;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic [LANES-1:0] lanes;
  } write_req_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_READ,
    ST_WRITE
  } access_t;
endpackage
`default_nettype wire

// *** logic/write_fifo.sv ***
/*
  Small synchronous FIFO with valid/ready on both sides.
  Assumes a single clock and an asynchronous active-low reset.
*/
`timescale 1ns/100ps
`default_nettype none
module write_fifo #(
  parameter int WIDTH = 39,
  parameter int DEPTH = 8
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
  localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

  logic [WIDTH-1:0] store [0:DEPTH-1];
  logic [PW-1:0] wr_ptr_r, wr_ptr_nxt, rd_ptr_r, rd_ptr_nxt;
  logic [CW-1:0] count_r, count_nxt;
  logic do_push, do_pop;

  assign in_ready = count_r != FULL_CNT;
  assign out_valid = count_r != '0;
  assign out_data = store[rd_ptr_r];
  assign do_push = in_valid && in_ready;
  assign do_pop = out_valid && out_ready;

  always_comb begin
    wr_ptr_nxt = wr_ptr_r;
    rd_ptr_nxt = rd_ptr_r;
    count_nxt = count_r;
    if (do_push) begin
      wr_ptr_nxt = (wr_ptr_r == LAST_PTR) ? '0 : wr_ptr_r + 1'b1;
    end
    if (do_pop) begin
      rd_ptr_nxt = (rd_ptr_r == LAST_PTR) ? '0 : rd_ptr_r + 1'b1;
    end
    if (do_push && !do_pop) begin
      count_nxt = count_r + 1'b1;
    end else if (do_pop && !do_push) begin
      count_nxt = count_r - 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
      count_r <= count_nxt;
    end
  end

  // Storage is not reset; only the pointers and count decide what is valid
  always_ff @(posedge clk_sys) begin
    if (do_push) begin
      store[wr_ptr_r] <= in_data;
    end
  end
endmodule
`default_nettype wire

// *** logic/flowthrough_burst_sram_port.sv ***
/*
  Flow-through burst SRAM port: select decode, load/advance, burst counter, byte-lane writes,
  output enable timing and the memory array, with a write FIFO between the pins and the array.
  Assumes all pin inputs are synchronous to clk_sys and the strap is stable from reset onward.
*/
`timescale 1ns/100ps
`default_nettype none
module flowthrough_burst_sram_port
  import sram_port_pkg::*;
#(
  parameter int FIFO_D = FIFO_DEPTH
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic clock_qualify_n,
  input wire logic write_n,
  input wire logic lane_a_write_sel_n,
  input wire logic lane_b_write_sel_n,
  input wire logic advance_or_load,
  input wire logic select_low_first,
  input wire logic select_high_second,
  input wire logic select_low_third,
  input wire logic output_gate_n,
  input wire logic burst_order_strap,
  input wire logic [DATA_W-1:0] dq_in,
  output logic [DATA_W-1:0] dq_out,
  output logic dq_oe,
  output logic write_accept,
  input wire logic tck,
  input wire logic tms,
  output logic tms_sampled
);
  logic [DATA_W-1:0] mem [0:MEM_WORDS-1];

  access_t state_r, state_nxt;
  logic [ADDR_W-1:0] base_r, base_nxt;
  logic [ADDR_W-1:0] wr_addr_r, wr_addr_nxt;
  logic [BURST_W-1:0] start_r, start_nxt, seq_r, seq_nxt;
  logic [LANES-1:0] wr_lanes_r, wr_lanes_nxt;
  logic [DATA_W-1:0] dq_out_r, dq_out_nxt;
  logic rd_phase_r, rd_phase_nxt, wr_phase_r, wr_phase_nxt;
  logic first_r, first_nxt;
  logic order_r, order_nxt, strap_taken_r;
  logic tck_prev_r, tms_r, tms_nxt;
  logic qualified, selected, access;
  logic [BURST_W-1:0] cnt;
  logic [ADDR_W-1:0] eff;
  write_req_t push_req, pop_req;
  logic push_valid, push_ready, pop_valid, pop_ready;

  assign qualified = !clock_qualify_n;
  assign selected = !select_low_first && select_high_second && !select_low_third;

  always_comb begin
    state_nxt = state_r;
    base_nxt = base_r;
    start_nxt = start_r;
    seq_nxt = seq_r;
    wr_addr_nxt = wr_addr_r;
    wr_lanes_nxt = wr_lanes_r;
    rd_phase_nxt = rd_phase_r;
    wr_phase_nxt = wr_phase_r;
    first_nxt = first_r;
    dq_out_nxt = dq_out_r;
    access = 1'b0;
    cnt = '0;
    eff = base_r;
    // Unqualified edges keep every field, stretching the previous cycle
    if (qualified) begin
      if (!advance_or_load) begin
        if (selected) begin
          state_nxt = write_n ? ST_READ : ST_WRITE;
          base_nxt = addr;
          start_nxt = addr[BURST_W-1:0];
          seq_nxt = SEQ_START;
          eff = addr;
          access = 1'b1;
          first_nxt = (state_r == ST_IDLE);
          wr_lanes_nxt = write_n ? '0 : ~{lane_b_write_sel_n, lane_a_write_sel_n};
        end else begin
          state_nxt = ST_IDLE;
          first_nxt = 1'b0;
        end
      end else if (state_r != ST_IDLE) begin
        seq_nxt = seq_r + SEQ_STEP;
        // Only the low bits move, so the burst wraps inside its group of four
        cnt = (order_r == STRAP_LINEAR) ? start_r + seq_nxt : start_r ^ seq_nxt;
        eff = {base_r[ADDR_W-1:BURST_W], cnt};
        access = 1'b1;
        first_nxt = 1'b0;
        wr_lanes_nxt = (state_r == ST_WRITE) ? ~{lane_b_write_sel_n, lane_a_write_sel_n} : '0;
      end else begin
        first_nxt = 1'b0;
      end
      rd_phase_nxt = access && (state_nxt == ST_READ);
      wr_phase_nxt = access && (state_nxt == ST_WRITE);
      if (access) begin
        wr_addr_nxt = eff;
      end
      if (rd_phase_nxt) begin
        dq_out_nxt = mem[eff];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      base_r <= '0;
      start_r <= SEQ_START;
      seq_r <= SEQ_START;
      wr_addr_r <= '0;
      wr_lanes_r <= '0;
      rd_phase_r <= 1'b0;
      wr_phase_r <= 1'b0;
      first_r <= 1'b0;
      dq_out_r <= DATA_RESET;
    end else begin
      state_r <= state_nxt;
      base_r <= base_nxt;
      start_r <= start_nxt;
      seq_r <= seq_nxt;
      wr_addr_r <= wr_addr_nxt;
      wr_lanes_r <= wr_lanes_nxt;
      rd_phase_r <= rd_phase_nxt;
      wr_phase_r <= wr_phase_nxt;
      first_r <= first_nxt;
      dq_out_r <= dq_out_nxt;
    end
  end

  // Strap caught once after reset release, never through the reset branch
  assign order_nxt = strap_taken_r ? order_r : burst_order_strap;
  // Test clock is a plain synchronous input, edge found against its last sample
  assign tms_nxt = (tck && !tck_prev_r) ? tms : tms_r;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      order_r <= STRAP_LINEAR;
      strap_taken_r <= 1'b0;
      tck_prev_r <= 1'b0;
      tms_r <= 1'b0;
    end else begin
      order_r <= order_nxt;
      strap_taken_r <= 1'b1;
      tck_prev_r <= tck;
      tms_r <= tms_nxt;
    end
  end

  assign dq_out = dq_out_r;
  assign dq_oe = rd_phase_r && !first_r && !output_gate_n;
  assign tms_sampled = tms_r;

  // Write data phase follows its address edge by one qualified edge
  assign push_valid = qualified && wr_phase_r && (wr_lanes_r != '0);
  assign push_req = '{addr: wr_addr_r, data: dq_in, lanes: wr_lanes_r};
  assign write_accept = push_ready;
  // Array has one port: a read on this edge stalls the drain.
  // Limitation: a read of a word still queued returns its old contents.
  assign pop_ready = !(qualified && rd_phase_nxt);

  write_fifo #(
    .WIDTH($bits(write_req_t)),
    .DEPTH(FIFO_D)
  ) u_write_fifo (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .in_data(push_req),
    .out_valid(pop_valid),
    .out_ready(pop_ready),
    .out_data(pop_req)
  );

  // One writer for the whole array; a process per lane would give each word two drivers
  always_ff @(posedge clk_sys) begin
    for (int g = 0; g < LANES; g++) begin
      if (pop_valid && pop_ready && pop_req.lanes[g]) begin
        mem[pop_req.addr][g*LANE_W +: LANE_W] <= pop_req.data[g*LANE_W +: LANE_W];
      end
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_hold_unqualified: assert property (clock_qualify_n |=>
    $stable(state_r) && $stable(seq_r) && $stable(base_r) && $stable(dq_out_r))
    else $error("state moved on an unqualified edge");
  a_ignore_edge: assert property (clock_qualify_n && !advance_or_load && selected |=>
    $stable(base_r)) else $error("address loaded while clock qualify high");
  a_load_address: assert property (qualified && !advance_or_load && selected |=>
    base_r == $past(addr) && seq_r == SEQ_START) else $error("address not loaded");
  a_burst_step: assert property (qualified && advance_or_load && state_r != ST_IDLE |=>
    seq_r == $past(seq_r) + SEQ_STEP) else $error("burst counter did not step");
  a_group_wrap: assert property (qualified && advance_or_load && state_r != ST_IDLE |=>
    wr_addr_r[ADDR_W-1:BURST_W] == base_r[ADDR_W-1:BURST_W]) else $error("burst left its group");
  a_select_terms: assert property (qualified && !advance_or_load && !selected |=>
    state_r == ST_IDLE && !dq_oe) else $error("device active without full select");
  a_high_select: assert property (qualified && !advance_or_load && !select_high_second |=>
    state_r == ST_IDLE) else $error("second select not active high");
  a_strobe_type: assert property (qualified && !advance_or_load && selected |=>
    state_r == ($past(write_n) ? ST_READ : ST_WRITE)) else $error("write strobe decoded wrongly");
  a_float_write: assert property (wr_phase_r || state_r == ST_IDLE || first_r |-> !dq_oe)
    else $error("data driven while it must float");
  a_tms_sample: assert property (tck && !tck_prev_r |=> tms_r == $past(tms))
    else $error("test mode select not sampled");
  // Read edges stall the drain, so the word cannot change under the check
  a_read_data: assert property (qualified && !advance_or_load && selected && write_n |=>
    dq_out_r == mem[$past(addr)]) else $error("read data not from loaded address");
  a_strap_hold: assert property (strap_taken_r |=> $stable(order_r))
    else $error("burst order changed after capture");
  a_first_mask: assert property (qualified && !advance_or_load && selected && state_r == ST_IDLE |=>
    !dq_oe) else $error("data driven on first cycle after deselect");

  c_read_burst: cover property (state_r == ST_READ && qualified && advance_or_load ##1 dq_oe);
  c_write_push: cover property (push_valid && push_ready);
  c_fifo_full: cover property (!push_ready);
  c_stretch: cover property (rd_phase_r ##1 clock_qualify_n [*3] ##1 qualified);
endmodule
`default_nettype wire

// *** test/host_ctrl_model.sv ***
/*
  Host memory controller model that drives the SRAM pin bus.
  Assumes clk_sys comes from the bench and every op is entered 1 ns after a rising edge.
*/
`timescale 1ns/100ps
`default_nettype none
module host_ctrl_model
  import sram_port_pkg::*;
(
  input wire logic clk_sys,
  output logic [ADDR_W-1:0] addr,
  output logic clock_qualify_n,
  output logic write_n,
  output logic [1:0] lanes_n,
  output logic advance_or_load,
  output logic [2:0] sel,
  output logic [DATA_W-1:0] dq_in
);
  initial begin
    {addr, clock_qualify_n, write_n, lanes_n, advance_or_load} = '0;
    sel = 3'h5;
    dq_in = '0;
  end
  // One qualified bus cycle, returns once the edge has been taken
  task automatic op(input logic [2:0] s, input logic adv, input logic wr, input logic [1:0] ln,
                    input logic [ADDR_W-1:0] a, input logic dv, input logic [DATA_W-1:0] d);
    sel = s;
    advance_or_load = adv;
    write_n = !wr;
    lanes_n = ln;
    addr = a;
    dq_in = dv ? d : ~dq_in; // Undriven data toggles so stale values never match
    @(posedge clk_sys);
    #1;
  endtask
  task automatic stall(input int n);
    clock_qualify_n = 1'b1;
    dq_in = ~dq_in;
    repeat (n) @(posedge clk_sys);
    #1;
    clock_qualify_n = 1'b0;
  endtask
endmodule
`default_nettype wire

// *** test/flowthrough_burst_sram_port_tb.sv ***
/*
  Self-checking bench for the SRAM port: bursts in both orders, lanes, stall, select, test port.
  Assumes the host model drives the pin bus and the bench owns reset, strap and test pins.
*/
`timescale 1ns/100ps
`default_nettype none
module flowthrough_burst_sram_port_tb;
  import sram_port_pkg::*;
  logic clk_sys, rst_n, strap, tck, tms, cqn, wn, adv, oe, wacc, tms_s, og_n;
  logic [1:0] ln;
  logic [2:0] sel;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] dq_in, dq_out;
  int mismatches = 0;
  int num_checks = 0;
  localparam logic [2:0] ON = 3'h2;
  localparam logic [2:0] OFF = 3'h5;
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  host_ctrl_model ctrl_u (.clk_sys(clk_sys), .addr(addr), .clock_qualify_n(cqn), .write_n(wn),
    .lanes_n(ln), .advance_or_load(adv), .sel(sel), .dq_in(dq_in));
  flowthrough_burst_sram_port dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .addr(addr),
    .clock_qualify_n(cqn), .write_n(wn), .lane_a_write_sel_n(ln[0]), .lane_b_write_sel_n(ln[1]),
    .advance_or_load(adv), .select_low_first(sel[2]), .select_high_second(sel[1]),
    .select_low_third(sel[0]), .output_gate_n(og_n), .burst_order_strap(strap), .dq_in(dq_in),
    .dq_out(dq_out), .dq_oe(oe), .write_accept(wacc), .tck(tck), .tms(tms), .tms_sampled(tms_s));
  task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) ctrl_u.op(OFF, 1'b0, 1'b0, 2'h3, '0, 1'b0, '0);
  endtask
  task automatic do_reset(input logic s);
    rst_n = 1'b0;
    strap = s;
    repeat (4) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask
  // Write a burst from start s, read the group back from 0 to see the order
  task automatic t_burst(input logic ilv, input logic [1:0] s);
    logic [1:0] k;
    ctrl_u.op(ON, 1'b0, 1'b1, 2'h0, 19'h5a6b0 | s, 1'b0, '0);
    for (int j = 1; j <= 4; j++) begin
      ctrl_u.op(j < 4 ? ON : OFF, j < 4, j < 4, 2'h0, 19'h7ffff, 1'b1, DATA_W'(255 + j));
      check(oe, 1'b0, "oe in write data");
    end
    idle(4);
    for (int j = 0; j < 4; j++) begin
      ctrl_u.op(ON, j > 0, 1'b0, 2'h3, 19'h5a6b0, 1'b0, '0);
      k = ilv ? (2'(j) ^ s) : (2'(j) - s);
      check(dq_out, DATA_W'(256 + k), "burst data");
      check(oe, j > 0, "oe after idle");
    end
    check(wacc, 1'b1, "fifo room");
  endtask
  // Lane a only, then a stalled read that must hold
  task automatic t_lanes();
    ctrl_u.op(ON, 1'b0, 1'b1, 2'h0, 19'h00124, 1'b0, '0);
    ctrl_u.op(ON, 1'b0, 1'b1, 2'h2, 19'h00124, 1'b1, 18'h3ffff);
    ctrl_u.op(OFF, 1'b0, 1'b0, 2'h3, '0, 1'b1, 18'h00000);
    idle(4);
    repeat (2) ctrl_u.op(ON, 1'b0, 1'b0, 2'h3, 19'h00124, 1'b0, '0);
    check(dq_out, 18'h3fe00, "lane a only");
    ctrl_u.sel = OFF;
    ctrl_u.stall(3);
    check(dq_out, 18'h3fe00, "stall data");
    check(oe, 1'b1, "stall oe");
    og_n = 1'b1;
    ctrl_u.op(ON, 1'b0, 1'b0, 2'h3, 19'h00124, 1'b0, '0);
    check(dq_out, 18'h3fe00, "gate high data");
    check(oe, 1'b0, "gate high oe");
    og_n = 1'b0;
  endtask
  task automatic t_desel();
    logic [2:0] v [3] = '{3'h0, 3'h3, 3'h6};
    foreach (v[i]) begin
      repeat (2) ctrl_u.op(ON, 1'b0, 1'b0, 2'h3, 19'h00124, 1'b0, '0);
      ctrl_u.op(v[i], 1'b0, 1'b0, 2'h3, 19'h00124, 1'b0, '0);
      check(oe, 1'b0, "partial select");
    end
  endtask
  // Test mode-select only moves on a test-clock rise
  task automatic t_tap();
    tms = 1'b1;
    idle(1);
    tck = 1'b1;
    idle(2);
    check(tms_s, 1'b1, "tms on rise");
    tms = 1'b0;
    idle(2);
    check(tms_s, 1'b1, "tms without rise");
    tck = 1'b0;
    idle(1);
    tck = 1'b1;
    idle(2);
    check(tms_s, 1'b0, "tms second rise");
  endtask
  task automatic summarize();
    $display("Checks %0d, mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    rst_n = 1'b0;
    strap = STRAP_LINEAR;
    tck = 1'b0;
    tms = 1'b0;
    og_n = 1'b0;
    do_reset(STRAP_LINEAR);
    t_burst(1'b0, 2'h2);
    t_lanes();
    t_desel();
    t_tap();
    do_reset(~STRAP_LINEAR);
    t_burst(1'b1, 2'h1);
    summarize();
  end
  // Whole run is under a hundred cycles; this is far beyond it
  initial begin
    #100000;
    mismatches++;
    summarize();
  end
endmodule
`default_nettype wire
